// ---- tx_char_input.sv ----
/*
 * Transmit character input register, parity checker, BIST progress and
 * phase-align fault reporting for four lanes, with an APB register slave.
 * Assumes reference and lane clocks are slow against clk (at least 4x),
 * and that host data is stable around the selected capture edge.
 */
`default_nettype none

module tx_char_input
    import tx_in_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reference_clock_in,
    input wire logic [3:0] per_lane_tx_clock,
    input wire logic [3:0][7:0] tx_char_byte,
    input wire logic [3:0][1:0] tx_char_control,
    input wire logic [3:0] tx_odd_parity_in,
    input wire logic special_char_select,
    input wire logic tx_align_recenter_n,
    output logic [3:0] tx_lane_fault_flag,
    output logic [3:0][9:0] tx_enc_char,
    output logic [3:0][1:0] tx_char_kind,
    output logic [3:0] tx_char_valid,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Odd parity check; true when the character is good
    function automatic logic odd_ok(input logic [7:0] b, input logic [1:0] c,
                                    input logic p, input logic with_ctrl);
        odd_ok = (^b) ^ p ^ (with_ctrl & (^c));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for every pin from outside clk
    logic ref_s1, ref_s2, ref_s3;
    logic [3:0] lck_s1, lck_s2, lck_s3;
    logic [3:0][7:0] byte_s1, byte_s2;
    logic [3:0][1:0] ctl_s1, ctl_s2;
    logic [3:0] par_s1, par_s2;
    logic scs_s1, scs_s2, rcn_s1, rcn_s2;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {ref_s1, ref_s2, ref_s3} <= 3'h0;
            {lck_s1, lck_s2, lck_s3} <= 12'h000;
            byte_s1 <= '0;
            byte_s2 <= '0;
            ctl_s1 <= '0;
            ctl_s2 <= '0;
            par_s1 <= 4'hf;
            par_s2 <= 4'hf;
            {scs_s1, scs_s2} <= 2'h0;
            {rcn_s1, rcn_s2} <= 2'h3;
        end
        else
        begin
            {ref_s1, ref_s2, ref_s3} <= {reference_clock_in, ref_s1, ref_s2};
            {lck_s1, lck_s2, lck_s3} <= {per_lane_tx_clock, lck_s1, lck_s2};
            byte_s1 <= tx_char_byte;
            byte_s2 <= byte_s1;
            ctl_s1 <= tx_char_control;
            ctl_s2 <= ctl_s1;
            par_s1 <= tx_odd_parity_in;
            par_s2 <= par_s1;
            {scs_s1, scs_s2} <= {special_char_select, scs_s1};
            {rcn_s1, rcn_s2} <= {tx_align_recenter_n, rcn_s1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration fields and edge strobes
    logic [31:0] ctrl, mask, status;
    logic [1:0] cksel, rxsel, mode, parsel;
    logic half;
    logic [3:0] bist_en;
    logic ref_rise, ref_fall, ref_tick, enc_on, align_on, sc_strobe;
    logic [3:0] lane_rise, strobe;
    logic [9:0] bist_last;

    assign cksel = ctrl[F_CKSEL +: 2];
    assign half = ctrl[F_HALF];
    assign rxsel = ctrl[F_RXSEL +: 2];
    assign mode = ctrl[F_MODE +: 2];
    assign parsel = ctrl[F_PAR +: 2];
    assign bist_en = ctrl[F_BIST +: 4];
    assign enc_on = (mode != SEL_LOW);
    assign align_on = (cksel != SEL_LOW) || half;
    assign ref_rise = ref_s2 & ~ref_s3;
    assign ref_fall = ~ref_s2 & ref_s3;
    // Character-rate tick; half rate uses both reference edges
    assign ref_tick = ref_rise | (half & ref_fall);
    assign lane_rise = lck_s2 & ~lck_s3;
    // Lane A clock is per_lane_tx_clock[0]
    assign sc_strobe = (cksel == SEL_MID) ? lane_rise[0] : strobe[0];
    assign bist_last = (rxsel == SEL_MID) ? BIST_PERIOD - 10'h001
                                          : BIST_PERIOD + WSYNC_LEN - 10'h001;

    // Capture strobe per lane from the input clock select
    always_comb
    begin
        for (int i = 0; i < LANES; i++)
        begin
            case (cksel)
                SEL_LOW: strobe[i] = ref_tick;
                SEL_MID: strobe[i] = lane_rise[i];
                SEL_HIGH: strobe[i] = lane_rise[0];
                default: strobe[i] = ref_tick;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lane datapath, BIST progress and align fault state
    logic sc_cap, next_sc_cap;
    logic [3:0][9:0] next_enc_char;
    logic [3:0][1:0] next_kind;
    logic [3:0] next_valid, par_pend, next_par_pend, fault_a, next_fault_a;
    logic [3:0] next_fault, perr, wsync_sent;
    logic [3:0][9:0] bist_cnt, next_bist_cnt;
    logic [3:0][4:0] bist_left, next_bist_left;
    logic [3:0][2:0] occ, next_occ;
    logic [1:0] rc_cnt, next_rc_cnt;
    logic recenter_hit;
    logic [11:0] events;

    always_comb
    begin
        next_sc_cap = sc_strobe ? scs_s2 : sc_cap;
        // Recenter needs two consecutive low reference rising edges
        next_rc_cnt = rc_cnt;
        if (ref_rise)
            next_rc_cnt = rcn_s2 ? 2'h0 : ((rc_cnt == RECENTER_EDGES) ? rc_cnt : rc_cnt + 2'h1);
        recenter_hit = ref_rise && !rcn_s2 && (rc_cnt == RECENTER_EDGES - 2'h1);
        events = 12'h000;
        for (int i = 0; i < LANES; i++)
        begin
            next_enc_char[i] = tx_enc_char[i];
            next_kind[i] = tx_char_kind[i];
            next_valid[i] = strobe[i];
            perr[i] = (parsel != SEL_LOW) &&
                      !odd_ok(byte_s2[i], ctl_s2[i], par_s2[i], parsel == SEL_HIGH);
            wsync_sent[i] = strobe[i] && enc_on && (ctl_s2[i] == CT_WSYNC) && next_sc_cap;
            if (strobe[i])
            begin
                // Bypassed: control bits are the top two data bits
                next_enc_char[i] = perr[i] ? BAD_CHAR_CODE : {ctl_s2[i], byte_s2[i]};
                case (ctl_s2[i])
                    CT_DATA: next_kind[i] = KIND_DATA;
                    CT_SPECIAL: next_kind[i] = KIND_SPECIAL;
                    CT_FILL: next_kind[i] = KIND_FILL;
                    CT_WSYNC: next_kind[i] = next_sc_cap ? KIND_WSYNC : KIND_SPECIAL;
                    default: next_kind[i] = KIND_DATA;
                endcase
                if (!enc_on)
                    next_kind[i] = KIND_DATA;
            end
            // Parity pend lasts one character tick; set wins over clear
            next_par_pend[i] = (par_pend[i] && !ref_tick) || (strobe[i] && perr[i]);
            events[S_PAR + i] = strobe[i] && perr[i];
            // BIST pass counter at character rate
            next_bist_cnt[i] = bist_cnt[i];
            next_bist_left[i] = bist_left[i];
            if (!bist_en[i])
            begin
                next_bist_cnt[i] = 10'h000;
                next_bist_left[i] = 5'h00;
            end
            else if (ref_tick)
            begin
                if (bist_left[i] != 5'h00)
                    next_bist_left[i] = bist_left[i] - 5'h01;
                if (bist_cnt[i] >= bist_last)
                begin
                    next_bist_cnt[i] = 10'h000;
                    next_bist_left[i] = (rxsel != SEL_MID && enc_on) ? BIST_LONG : BIST_SHORT;
                    events[S_BIST + i] = 1'b1;
                end
                else
                    next_bist_cnt[i] = bist_cnt[i] + 10'h001;
            end
            // Align buffer: lane writes raise, character reads lower occupancy
            next_occ[i] = occ[i];
            next_fault_a[i] = fault_a[i];
            if (!align_on || recenter_hit)
                next_occ[i] = OCC_CENTER;
            else if (strobe[i] && !ref_tick)
                next_occ[i] = (occ[i] == OCC_MAX) ? occ[i] : occ[i] + 3'h1;
            else if (ref_tick && !strobe[i])
                next_occ[i] = (occ[i] == 3'h0) ? occ[i] : occ[i] - 3'h1;
            if (align_on && (recenter_hit || wsync_sent[i]))
                next_fault_a[i] = 1'b0;
            if (align_on && !recenter_hit && ((strobe[i] && !ref_tick && occ[i] == OCC_MAX) ||
                (ref_tick && !strobe[i] && occ[i] == 3'h0)))
            begin
                next_fault_a[i] = 1'b1;
                events[S_ALIGN + i] = !fault_a[i];
            end
            if (!align_on)
                next_fault_a[i] = 1'b0;
            // Flag changes only at character ticks; BIST replaces parity
            next_fault[i] = tx_lane_fault_flag[i];
            if (ref_tick)
                next_fault[i] = bist_en[i] ? (next_bist_left[i] != 5'h00)
                                           : (next_par_pend[i] || next_fault_a[i]);
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sc_cap <= 1'b0;
            rc_cnt <= 2'h0;
            tx_enc_char <= '0;
            tx_char_kind <= '0;
            tx_char_valid <= 4'h0;
            par_pend <= 4'h0;
            bist_cnt <= '0;
            bist_left <= '0;
            occ <= {LANES{OCC_CENTER}};
            fault_a <= 4'h0;
            tx_lane_fault_flag <= 4'h0;
        end
        else
        begin
            sc_cap <= next_sc_cap;
            rc_cnt <= next_rc_cnt;
            tx_enc_char <= next_enc_char;
            tx_char_kind <= next_kind;
            tx_char_valid <= next_valid;
            par_pend <= next_par_pend;
            bist_cnt <= next_bist_cnt;
            bist_left <= next_bist_left;
            occ <= next_occ;
            fault_a <= next_fault_a;
            tx_lane_fault_flag <= next_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero-wait, pready raised in the first access cycle
    logic [31:0] next_ctrl, next_mask, next_status, next_prdata;
    logic next_pready, next_pslverr, next_irq, setup, done;
    logic map_hit;

    assign setup = psel && !penable;
    assign done = psel && penable && pready;
    assign map_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_MASK);

    always_comb
    begin
        next_ctrl = ctrl;
        next_mask = mask;
        next_pready = setup;
        next_pslverr = setup && !map_hit;
        next_prdata = prdata;
        next_status = status;
        if (setup)
        begin
            case (paddr)
                ADDR_CTRL: next_prdata = ctrl;
                ADDR_STATUS: next_prdata = status;
                ADDR_MASK: next_prdata = mask;
                default: next_prdata = 32'h0000_0000;
            endcase
        end
        if (done && pwrite && paddr == ADDR_CTRL)
            next_ctrl = {19'h00000, pwdata[12:0]};
        if (done && pwrite && paddr == ADDR_MASK)
            next_mask = {20'h00000, pwdata[11:0]};
        // Read clears only the bits returned; a new event still wins
        if (done && !pwrite && paddr == ADDR_STATUS)
            next_status = status & ~prdata;
        next_status = next_status | {20'h00000, events};
        next_irq = |(status & mask);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= CTRL_RESET;
            mask <= 32'h0000_0000;
            status <= 32'h0000_0000;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            mask <= next_mask;
            status <= next_status;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on lane 0; align, flag-tick and reference-capture checks cover every lane, since any lane may starve
    sequence s_wrap;
        bist_en[0] && ref_tick && (bist_cnt[0] >= bist_last);
    endsequence

    AST_BAD_CHAR: assert property (@(posedge clk) disable iff (!rstn)
        strobe[0] && perr[0] |=> tx_enc_char[0] == BAD_CHAR_CODE)
        else $error("parity failure not replaced by bad code");
    AST_PAR_FLAG: assert property (@(posedge clk) disable iff (!rstn)
        strobe[0] && perr[0] && ref_tick && !bist_en[0] |=> tx_lane_fault_flag[0])
        else $error("parity failure did not raise fault flag");
    AST_FLAG_TICK: assert property (@(posedge clk) disable iff (!rstn)
        !ref_tick |=> $stable(tx_lane_fault_flag))
        else $error("fault flag moved off a character tick");
    AST_ALIGN_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        align_on && !recenter_hit |=> ($past(fault_a & ~wsync_sent) & ~fault_a) == 4'h0)
        else $error("align fault dropped without cause");
    AST_ALIGN_CLR: assert property (@(posedge clk) disable iff (!rstn)
        ($past(fault_a & ~wsync_sent) & ~fault_a) != 4'h0 |-> $past(recenter_hit || !align_on))
        else $error("align fault cleared without sync or recenter");
    AST_REF_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
        (cksel == SEL_LOW) && ref_tick |=> tx_char_valid == 4'hf)
        else $error("low select captured off the reference tick");
    AST_BIST_SHORT: assert property (@(posedge clk) disable iff (!rstn)
        s_wrap ##0 (rxsel == SEL_MID) |=> bist_left[0] == BIST_SHORT)
        else $error("short BIST pulse length wrong");
    AST_BIST_LONG: assert property (@(posedge clk) disable iff (!rstn)
        s_wrap ##0 (rxsel != SEL_MID && enc_on) |=> bist_left[0] == BIST_LONG && bist_cnt[0] == 10'h000)
        else $error("long BIST pulse or counter wrap wrong");
    AST_PAR_OFF: assert property (@(posedge clk) disable iff (!rstn)
        strobe[0] && parsel == SEL_LOW |=> tx_enc_char[0] == $past({ctl_s2[0], byte_s2[0]}))
        else $error("character altered with parity off");
    AST_SC_LANE_A: assert property (@(posedge clk) disable iff (!rstn)
        (cksel == SEL_MID) && lane_rise[0] |=> sc_cap == $past(scs_s2))
        else $error("special select not taken on lane A edge");

endmodule

`default_nettype wire

// ---- tx_in_pkg.sv ----
/*
 * Constants for the parallel transmit character input of a four-lane serializer.
 * Assumes one 20 MHz system clock; all link clocks are sampled as data.
 */
`default_nettype none

package tx_in_pkg;
    localparam int LANES = 4;
    // Three-level select encodings
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_MID = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    // Control field codes with the encoder enabled
    localparam logic [1:0] CT_DATA = 2'h0;
    localparam logic [1:0] CT_SPECIAL = 2'h1;
    localparam logic [1:0] CT_FILL = 2'h2;
    localparam logic [1:0] CT_WSYNC = 2'h3;
    // Character kind handed to the encoder
    localparam logic [1:0] KIND_DATA = 2'h0;
    localparam logic [1:0] KIND_SPECIAL = 2'h1;
    localparam logic [1:0] KIND_FILL = 2'h2;
    localparam logic [1:0] KIND_WSYNC = 2'h3;
    // Bad character code (C0.7) sent in place of a parity failure
    localparam logic [9:0] BAD_CHAR_CODE = 10'h0e0;
    // BIST timing in character periods
    localparam logic [9:0] BIST_PERIOD = 10'h1ff;
    localparam logic [9:0] WSYNC_LEN = 10'h010;
    localparam logic [4:0] BIST_LONG = 5'h11;
    localparam logic [4:0] BIST_SHORT = 5'h01;
    // Align buffer occupancy model
    localparam logic [2:0] OCC_CENTER = 3'h2;
    localparam logic [2:0] OCC_MAX = 3'h3;
    localparam logic [1:0] RECENTER_EDGES = 2'h2;
    // APB register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Control register fields
    localparam int F_CKSEL = 0;
    localparam int F_HALF = 2;
    localparam int F_RXSEL = 3;
    localparam int F_MODE = 5;
    localparam int F_PAR = 7;
    localparam int F_BIST = 9;
    // Status fields: parity [3:0], BIST pass [7:4], align fault [11:8]
    localparam int S_PAR = 0;
    localparam int S_BIST = 4;
    localparam int S_ALIGN = 8;
endpackage

`default_nettype wire

// ---- tx_host_model.sv ----
/*
 * Host model: reference and lane clocks, random characters with odd parity.
 * Assumes clk at 20 MHz; every link clock spans 8 clk periods (400 ns).
 */
`default_nettype none

module tx_host_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] lane_run,
    input wire logic [1:0] par_mode,
    input wire logic err_en,
    output logic reference_clock_in,
    output logic [3:0] per_lane_tx_clock,
    output logic [3:0][7:0] tx_char_byte,
    output logic [3:0][1:0] tx_char_control,
    output logic [3:0] tx_odd_parity_in,
    output logic special_char_select,
    output logic [3:0][10:0] snap,
    output logic snap_sc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] phase;
    logic [9:0] ch;
    logic bad;

    ////////////////////////////////////////////////////////////
    // Reference runs free; a stopped lane clock stands low
    assign reference_clock_in = phase[2];
    assign per_lane_tx_clock = {4{phase[2]}} & lane_run;

    // Data moves half a period from the rising edge, margin on both sides
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase <= 3'h0;
            {tx_char_byte, tx_char_control, tx_odd_parity_in} <= '0;
            {special_char_select, snap, snap_sc} <= '0;
        end
        else
        begin
            phase <= phase + 3'h1;
            if (phase == 3'h7)
            begin
                for (int i = 0; i < 4; i++)
                begin
                    ch = 10'($urandom);
                    bad = err_en && ($urandom_range(3) == 0);
                    tx_char_byte[i] <= ch[7:0];
                    tx_char_control[i] <= ch[9:8];
                    tx_odd_parity_in[i] <= bad ^ ~^{ch[7:0], par_mode[1] ? ch[9:8] : 2'h0};
                end
                special_char_select <= 1'($urandom);
            end
            // What stood on the pins at the rising edge
            if (phase == 3'h3)
            begin
                for (int i = 0; i < 4; i++)
                    snap[i] <= {tx_odd_parity_in[i], tx_char_control[i], tx_char_byte[i]};
                snap_sc <= special_char_select;
            end
        end
    end
endmodule

`default_nettype wire

// ---- serdes_tx_parallel_input_bench.sv ----
/*
 * Self-checking bench for the transmit character input block.
 * Assumes tx_host_model as the host and a zero-wait APB slave.
 */
`default_nettype none

module serdes_tx_parallel_input_bench
    import tx_in_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, rerr, chk_on, err_en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, cur_ctrl;
    logic reference_clock_in, special_char_select, tx_align_recenter_n, snap_sc;
    logic [3:0] per_lane_tx_clock, tx_odd_parity_in, tx_lane_fault_flag, tx_char_valid;
    logic [3:0][7:0] tx_char_byte;
    logic [3:0][1:0] tx_char_control, tx_char_kind;
    logic [3:0][9:0] tx_enc_char;
    logic [3:0][10:0] snap;
    logic [3:0] lane_run;
    logic [1:0] par_mode;
    int errors, samples_checked, cycles, n;
    int bad_caps[4];
    int flag_hi[4];

    ////////////////////////////////////////////////////////////
    tx_char_input u_tx_char_input (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .reference_clock_in, .per_lane_tx_clock, .tx_char_byte,
        .tx_char_control, .tx_odd_parity_in, .special_char_select, .tx_align_recenter_n,
        .tx_lane_fault_flag, .tx_enc_char, .tx_char_kind, .tx_char_valid, .irq);
    tx_host_model u_tx_host_model (.clk, .rstn, .lane_run, .par_mode, .err_en,
        .reference_clock_in, .per_lane_tx_clock, .tx_char_byte, .tx_char_control,
        .tx_odd_parity_in, .special_char_select, .snap, .snap_sc);

    // 50 ns clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard, well above the BIST phases
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errors++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 32'h0);
        check(rdat, exp, "read data");
        check(32'(rerr), 32'(eexp), "slave error");
    endtask

    function automatic logic [31:0] mk(input logic [1:0] ck, input logic half,
        input logic [1:0] rx, input logic [1:0] md, input logic [1:0] pm, input logic [3:0] bi);
        return (32'(ck) << F_CKSEL) | (32'(half) << F_HALF) | (32'(rx) << F_RXSEL)
            | (32'(md) << F_MODE) | (32'(pm) << F_PAR) | (32'(bi) << F_BIST);
    endfunction

    // Character checks are paused while the mode settles
    task automatic setm(input logic [31:0] c, input logic on);
        chk_on <= 1'b0;
        apb(1'b1, ADDR_CTRL, c);
        cur_ctrl <= c;
        par_mode <= c[F_PAR +: 2];
        repeat (32) @(posedge clk);
        chk_on <= on;
    endtask

    task automatic countv(input int lane, input int exp);
        int c;
        c = 0;
        repeat (160) @(posedge clk) c += int'(tx_char_valid[lane] === 1'b1);
        check(32'(c), 32'(exp), "capture count");
    endtask

    task automatic bist(input int w, input int p);
        int a;
        int b;
        a = 0;
        b = 0;
        while (tx_lane_fault_flag[0] === 1'b1) @(posedge clk);
        while (tx_lane_fault_flag[0] !== 1'b1) @(posedge clk);
        while (tx_lane_fault_flag[0] === 1'b1) @(posedge clk) a++;
        while (tx_lane_fault_flag[0] !== 1'b1) @(posedge clk) b++;
        check(32'(a), 32'(w), "pass width");
        check(32'(a + b), 32'(p), "pass period");
    endtask

    function automatic logic eerr(input logic [10:0] s);
        logic [1:0] pm;
        pm = cur_ctrl[F_PAR +: 2];
        return (pm != SEL_LOW) && !(^{s[10], s[7:0], (pm == SEL_HIGH) ? s[9:8] : 2'h0});
    endfunction

    function automatic logic [1:0] ekind(input logic [10:0] s, input logic sc);
        if (cur_ctrl[F_MODE +: 2] == 2'h0)
            return KIND_DATA;
        if (s[9:8] == CT_WSYNC)
            return sc ? KIND_WSYNC : KIND_SPECIAL;
        return s[9:8];
    endfunction

    ////////////////////////////////////////////////////////////
    // Every captured character against what the host presented
    always @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
        begin
            flag_hi[i] += int'(tx_lane_fault_flag[i] === 1'b1);
            if (chk_on === 1'b1 && tx_char_valid[i] === 1'b1 && eerr(snap[i]))
            begin
                bad_caps[i]++;
                check(32'(tx_enc_char[i]), 32'(BAD_CHAR_CODE), "bad char");
            end
            else if (chk_on === 1'b1 && tx_char_valid[i] === 1'b1)
            begin
                check(32'(tx_enc_char[i]), 32'(snap[i][9:0]), "char");
                check(32'(tx_char_kind[i]), 32'(ekind(snap[i], snap_sc)), "kind");
            end
        end
    end

    // Main sequence
    initial
    begin
        {rstn, psel, penable, pwrite, err_en, chk_on} = '0;
        paddr = 8'h0;
        pwdata = 32'h0;
        cur_ctrl = 32'h0;
        tx_align_recenter_n = 1'b1;
        lane_run = 4'hf;
        par_mode = 2'h0;
        void'($urandom(32'h3b8de563));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rdc(ADDR_CTRL, CTRL_RESET, 1'b0);
        rdc(ADDR_MASK, 32'h0, 1'b0);
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        rdc(8'h0c, 32'h0, 1'b1);
        rdc(ADDR_STATUS, 32'h0, 1'b0);
        // Every parity selection, encoder off and on, random faults
        err_en <= 1'b1;
        for (int pm = 0; pm < 3; pm++)
            for (int md = 0; md < 2; md++)
            begin
                setm(mk(SEL_LOW, 1'b0, SEL_MID, md ? 2'($urandom_range(1, 3)) : 2'h0,
                    2'(pm), 4'h0), 1'b1);
                rdc(ADDR_CTRL, cur_ctrl, 1'b0);
                repeat (160) @(posedge clk);
            end
        // Flag time per bad character, then status, mask and interrupt
        err_en <= 1'b0;
        repeat (40) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        bad_caps = '{default: 0};
        flag_hi = '{default: 0};
        err_en <= 1'b1;
        repeat (320) @(posedge clk);
        err_en <= 1'b0;
        repeat (48) @(posedge clk);
        n = 0;
        for (int i = 0; i < 4; i++)
        begin
            check(32'(flag_hi[i]), 32'(8 * bad_caps[i]), "fault flag cycles");
            n = n | (int'(bad_caps[i] != 0) << i);
        end
        check(32'(irq), 32'h0, "masked irq");
        apb(1'b1, ADDR_MASK, 32'hfff);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'(n != 0), "irq raised");
        rdc(ADDR_STATUS, 32'(n), 1'b0);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0, "irq cleared");
        // Half rate, then lane B clock stopped under the other selections
        setm(mk(SEL_LOW, 1'b1, SEL_MID, 2'h1, 2'h0, 4'h0), 1'b0);
        countv(0, 40);
        lane_run <= 4'b1101;
        setm(mk(SEL_HIGH, 1'b0, SEL_MID, 2'h1, 2'h0, 4'h0), 1'b1);
        countv(1, 20);
        // Encoder off: a random word sync would clear the fault we expect held
        setm(mk(SEL_MID, 1'b0, SEL_MID, 2'h0, 2'h0, 4'h0), 1'b1);
        countv(1, 0);
        countv(2, 20);
        check(32'(tx_lane_fault_flag[1]), 32'h1, "align fault");
        lane_run <= 4'hf;
        repeat (80) @(posedge clk);
        check(32'(tx_lane_fault_flag[1]), 32'h1, "align fault held");
        tx_align_recenter_n <= 1'b0;
        repeat (24) @(posedge clk);
        tx_align_recenter_n <= 1'b1;
        repeat (40) @(posedge clk);
        check(32'(tx_lane_fault_flag), 32'h0, "align cleared");
        // BIST progress on lane A under both receive clock selections
        setm(mk(SEL_LOW, 1'b0, SEL_MID, 2'h1, 2'h0, 4'h1), 1'b0);
        bist(8, 511 * 8);
        setm(mk(SEL_LOW, 1'b0, SEL_LOW, 2'h1, 2'h0, 4'h1), 1'b0);
        bist(17 * 8, 527 * 8);
        end_sim();
    end
endmodule

`default_nettype wire
